// ### design/ifd_cfg.svh
/*
 Field positions, widths and opcode constants of the instruction field decoder.
 Assumes big-endian bit numbering: printed bit n is vector bit 31-n.
*/
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH
`define IFD_OPC_MSB        31
`define IFD_OPC_LSB        26
`define IFD_F6_10_MSB      25
`define IFD_F6_10_LSB      21
`define IFD_F11_15_MSB     20
`define IFD_F11_15_LSB     16
`define IFD_F16_20_MSB     15
`define IFD_F16_20_LSB     11
`define IFD_F6_8_MSB       25
`define IFD_F6_8_LSB       23
`define IFD_F11_13_MSB     20
`define IFD_F11_13_LSB     18
`define IFD_BD_MSB         15
`define IFD_BD_LSB         2
`define IFD_LI_MSB         25
`define IFD_LI_LSB         2
`define IFD_AA_BIT         1
`define IFD_LK_BIT         0
`define IFD_OPC_BC         6'h10
`define IFD_OPC_B          6'h12
`define IFD_OPC_CRLOG      6'h13
`define IFD_OPC_MCRFS      6'h3f
`define IFD_XO_MCRF        10'h000
`define IFD_XO_MCRFS       10'h040
`define IFD_NEXT_INC       32'h0000_0004
`endif

// ### design/ifd_pkg.sv
/*
 Types shared by the instruction field decoder.
 Assumes ifd_cfg.svh is in the include path.
*/
package ifd_pkg;
    typedef enum logic [1:0] {
        IFD_CLS_OTHER = 2'b00,
        IFD_CLS_BCOND = 2'b01,
        IFD_CLS_BUNC  = 2'b11,
        IFD_CLS_CRFLD = 2'b10
    } ifd_class_t;

    typedef struct packed {
        logic [5:0]  opcode;
        logic [4:0]  cond_bit_src_first;
        logic [4:0]  cond_bit_src_second;
        logic [4:0]  cond_bit_dest;
        logic [2:0]  cond_field_dest;
        logic [2:0]  cond_field_src;
        logic [4:0]  branch_test_select;
        logic [4:0]  branch_option_code;
        logic        absolute_target_flag;
        logic        link_update_flag;
    } ifd_fields_t;

    typedef struct packed {
        logic [31:0] target;
        logic [31:0] link_addr;
        logic        link_we;
        logic        is_branch;
    } ifd_branch_t;
endpackage

// ### design/ifd_target.sv
/*
 Combinational branch target adder of the instruction field decoder.
 Assumes instr and pc are held steady through the cycle in which the word is taken.
*/
`timescale 1ns/1ps
`include "ifd_cfg.svh"
module ifd_target (
    input  wire logic [31:0] instr,
    input  wire logic [31:0] pc,
    input  wire logic        is_cond,
    output logic      [31:0] target
);
    logic [31:0] disp;
    logic [31:0] sum;

    always_comb begin
        if (is_cond) begin
            disp = {{16{instr[`IFD_BD_MSB]}}, instr[`IFD_BD_MSB:`IFD_BD_LSB], 2'b00};
        end else begin
            disp = {{6{instr[`IFD_LI_MSB]}}, instr[`IFD_LI_MSB:`IFD_LI_LSB], 2'b00};
        end
    end

    // Low bits of pc dropped so a misaligned fetch address cannot leak in
    assign sum = disp + {pc[31:2], 2'b00};

    always_comb begin
        if (instr[`IFD_AA_BIT]) begin
            target = disp;
        end else begin
            target = sum;
        end
        target[1:0] = 2'b00;
    end
endmodule

// ### design/ifd_decoder.sv
/*
 Instruction field decoder: one registered stage from fetch to execution units.
 Assumes instr_valid is a one-cycle strobe from same-clock fetch logic.
*/
// Functional notes
// - Instructions are aligned words; address low bits ignored
// - Generated addresses have low two bits zero
// - Primary opcode from bits 0 to 5
// - Nonzero reserved field marks form invalid
// - Wrong fixed-value field marks form invalid
// - Split fields concatenated left to right
// - Relative target adds branch instruction address
// - Absolute target is displacement alone
// - Conditional displacement 14 bits, shifted, extended
// - Source condition bits from 11:15, 16:20
// - Destination condition field from bits 6:8
// - Source condition field from bits 11:13
// - Branch test bit from bits 11:15
// - Branch option code from bits 6:10
// - Destination condition bit from bits 6:10
// - Long offset 24 bits, shifted, extended
// - Link flag stores next instruction address
`timescale 1ns/1ps
`include "ifd_cfg.svh"
module ifd_decoder (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                instr_valid,
    input  wire logic [31:0]         instr,
    input  wire logic [31:0]         instr_addr,
    output logic                     dec_valid_q,
    output ifd_pkg::ifd_fields_t     fields_q,
    output ifd_pkg::ifd_branch_t     branch_q,
    output ifd_pkg::ifd_class_t      class_q,
    output logic                     invalid_form_q
);
    ifd_pkg::ifd_fields_t fields_d;
    ifd_pkg::ifd_branch_t branch_d;
    ifd_pkg::ifd_class_t  class_d;
    logic                 invalid_d;
    logic [31:0]          pc_al;
    logic [31:0]          target;
    logic [5:0]           opc;
    logic [9:0]           xo;

    function automatic logic [4:0] fld5(input logic [31:0] w, input int lsb);
        fld5 = 5'((w >> lsb) & 32'h0000_001f);
    endfunction

    assign pc_al = {instr_addr[31:2], 2'b00};
    assign opc   = instr[`IFD_OPC_MSB:`IFD_OPC_LSB];
    assign xo    = instr[10:1];

    ifd_target u_target (
        .instr   (instr),
        .pc      (pc_al),
        .is_cond (opc == `IFD_OPC_BC),
        .target  (target)
    );

    always_comb begin
        fields_d.opcode               = opc;
        fields_d.cond_bit_src_first   = fld5(instr, `IFD_F11_15_LSB);
        fields_d.cond_bit_src_second  = fld5(instr, `IFD_F16_20_LSB);
        fields_d.cond_bit_dest        = fld5(instr, `IFD_F6_10_LSB);
        fields_d.cond_field_dest      = instr[`IFD_F6_8_MSB:`IFD_F6_8_LSB];
        fields_d.cond_field_src       = instr[`IFD_F11_13_MSB:`IFD_F11_13_LSB];
        fields_d.branch_test_select   = fld5(instr, `IFD_F11_15_LSB);
        fields_d.branch_option_code   = fld5(instr, `IFD_F6_10_LSB);
        fields_d.absolute_target_flag = instr[`IFD_AA_BIT];
        fields_d.link_update_flag     = instr[`IFD_LK_BIT];
    end

    always_comb begin
        class_d   = ifd_pkg::IFD_CLS_OTHER;
        invalid_d = 1'b0;
        case (opc)
            `IFD_OPC_BC: begin
                class_d = ifd_pkg::IFD_CLS_BCOND;
            end
            `IFD_OPC_B: begin
                class_d = ifd_pkg::IFD_CLS_BUNC;
            end
            `IFD_OPC_CRLOG, `IFD_OPC_MCRFS: begin
                // Field moves: pad bits 9:10, 14:20, 31 reserved; xo fixed
                if ((opc == `IFD_OPC_CRLOG && xo == `IFD_XO_MCRF)
                    || (opc == `IFD_OPC_MCRFS && xo == `IFD_XO_MCRFS)) begin
                    class_d   = ifd_pkg::IFD_CLS_CRFLD;
                    invalid_d = (instr[22:21] != 2'b00) || (instr[17:11] != 7'h00)
                                || instr[0];
                end else if (opc == `IFD_OPC_MCRFS) begin
                    invalid_d = 1'b0;
                end else if (instr[0]) begin
                    // Condition-bit logic forms need link bit fixed at zero
                    invalid_d = 1'b1;
                end
            end
            default: begin
                class_d = ifd_pkg::IFD_CLS_OTHER;
            end
        endcase
    end

    // No split fields in the decoded set; all are contiguous, left to right
    always_comb begin
        branch_d.is_branch = (class_d == ifd_pkg::IFD_CLS_BCOND)
                             || (class_d == ifd_pkg::IFD_CLS_BUNC);
        branch_d.target    = target;
        branch_d.link_addr = pc_al + `IFD_NEXT_INC;
        branch_d.link_we   = branch_d.is_branch && instr[`IFD_LK_BIT];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dec_valid_q <= 1'b0;
        end else begin
            dec_valid_q <= instr_valid;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fields_q <= '0;
            branch_q <= '0;
            class_q  <= ifd_pkg::IFD_CLS_OTHER;
        end else if (instr_valid) begin
            fields_q <= fields_d;
            branch_q <= branch_d;
            class_q  <= class_d;
        end
    end

    // Flag travels with its word so exception logic can squash it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            invalid_form_q <= 1'b0;
        end else begin
            invalid_form_q <= instr_valid && invalid_d;
        end
    end

    // Checks look one edge after the word is taken
    AST_TGT_ALIGN: assert property (@(posedge clk) disable iff (sys_rst)
        dec_valid_q |-> branch_q.target[1:0] == 2'b00)
        else $error("target not word aligned");
    AST_OPCODE: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid |=> fields_q.opcode == $past(instr[31:26]))
        else $error("opcode not from top six bits");
    AST_REL: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_BC && !instr[1] |=>
        branch_q.target == ({{16{$past(instr[15])}}, $past(instr[15:2]), 2'b00}
        + {$past(instr_addr[31:2]), 2'b00}))
        else $error("relative target wrong");
    AST_ABS: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_B && instr[1] |=>
        branch_q.target == {{6{$past(instr[25])}}, $past(instr[25:2]), 2'b00})
        else $error("absolute target wrong");
    AST_LINK: assert property (@(posedge clk) disable iff (sys_rst)
        dec_valid_q && branch_q.link_we |->
        branch_q.link_addr == {$past(instr_addr[31:2]), 2'b00} + 32'h4)
        else $error("link address wrong");
    AST_SRCBITS: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid |=> fields_q.cond_bit_src_first == $past(instr[20:16])
        && fields_q.cond_bit_src_second == $past(instr[15:11]))
        else $error("source bit selectors wrong");
    AST_CRFIELDS: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid |=> fields_q.cond_field_dest == $past(instr[25:23])
        && fields_q.cond_field_src == $past(instr[20:18]))
        else $error("field selectors wrong");
    AST_BOBI: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid |=> fields_q.branch_option_code == $past(instr[25:21])
        && fields_q.branch_test_select == $past(instr[20:16]))
        else $error("branch option or test select wrong");
    AST_RSVD: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_CRLOG && instr[10:1] == 10'h000
        && instr[0] |=> invalid_form_q)
        else $error("reserved bit not flagged");
    AST_NOINV: assert property (@(posedge clk) disable iff (sys_rst)
        !instr_valid |=> !invalid_form_q)
        else $error("invalid flag without instruction");

    // Field extraction, target modes and form checks per opcode
    AST_VALID: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid |=> dec_valid_q)
        else $error("decode strobe missing");
    AST_DESTBIT: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid |=> fields_q.cond_bit_dest == $past(instr[25:21]))
        else $error("destination bit selector wrong");
    AST_SRCFLD: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid |=> fields_q.cond_field_src == $past(instr[20:18]))
        else $error("source field selector wrong");
    AST_TESTSEL: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_BC |=>
        fields_q.branch_test_select == $past(instr[20:16]))
        else $error("branch test select wrong");
    AST_AA_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid |=> fields_q.absolute_target_flag == $past(instr[1]))
        else $error("absolute flag wrong");
    AST_BC_ABS: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_BC && instr[1] |=>
        branch_q.target == {{16{$past(instr[15])}}, $past(instr[15:2]), 2'b00})
        else $error("conditional displacement wrong");
    AST_B_REL: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_B && !instr[1] |=>
        branch_q.target == ({{6{$past(instr[25])}}, $past(instr[25:2]), 2'b00}
        + {$past(instr_addr[31:2]), 2'b00}))
        else $error("long relative target wrong");
    AST_LINK_WE: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && (instr[31:26] == `IFD_OPC_BC || instr[31:26] == `IFD_OPC_B) |=>
        branch_q.link_we == $past(instr[0]))
        else $error("link write enable wrong");
    AST_FIXED: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_CRLOG && instr[10:1] != `IFD_XO_MCRF
        && instr[0] |=> invalid_form_q)
        else $error("fixed field not flagged");
    AST_FLD_CLS: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_MCRFS && instr[10:1] == `IFD_XO_MCRFS
        |=> class_q == ifd_pkg::IFD_CLS_CRFLD)
        else $error("field move not classed");
    AST_RSVD_PAD: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_CRLOG && instr[10:1] == `IFD_XO_MCRF
        && instr[22:21] != 2'b00 |=> invalid_form_q)
        else $error("reserved pad not flagged");
    AST_GOOD_FORM: assert property (@(posedge clk) disable iff (sys_rst)
        instr_valid && instr[31:26] == `IFD_OPC_MCRFS && instr[10:1] == `IFD_XO_MCRFS
        && instr[22:21] == 2'b00 && instr[17:11] == 7'h00 && !instr[0]
        |=> !invalid_form_q)
        else $error("clean field move flagged");

    COV_BC: cover property (@(posedge clk) instr_valid && instr[31:26] == `IFD_OPC_BC);
    COV_BL: cover property (@(posedge clk) dec_valid_q && branch_q.link_we);
    COV_INV: cover property (@(posedge clk) invalid_form_q);
    COV_CRFLD: cover property (@(posedge clk) dec_valid_q && class_q == ifd_pkg::IFD_CLS_CRFLD);
    COV_ABS: cover property (@(posedge clk) instr_valid && instr[31:26] == `IFD_OPC_B && instr[1]);
endmodule

// ### bench/ifd_fetch_model.sv
/*
 Fetch side model: hands one word per request to the decoder as a one-cycle strobe.
 Assumes the caller calls put and idle from one process, one clock edge each.
*/
`timescale 1ns/1ps
module ifd_fetch_model (
    input  wire logic        clk,
    output logic             instr_valid,
    output logic [31:0]      instr,
    output logic [31:0]      instr_addr
);
    initial begin
        instr_valid = 1'b0;
        instr       = 32'h0000_0000;
        instr_addr  = 32'h0000_0000;
    end
    task automatic put(input logic [31:0] w, input logic [31:0] a);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr       <= w;
        instr_addr  <= a;
    endtask
    // Stale word inverted so a held value never reads as valid
    task automatic idle();
        @(posedge clk);
        instr_valid <= 1'b0;
        instr       <= ~instr;
        instr_addr  <= ~instr_addr;
    endtask
endmodule

// ### bench/tb_top.sv
/*
 Self-checking testbench of the instruction field decoder.
 Assumes ifd_pkg compiled first and ifd_cfg.svh on the include path.
*/
`timescale 1ns/1ps
module tb_top;
    logic                 clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic                 instr_valid;
    logic [31:0]          instr;
    logic [31:0]          instr_addr;
    logic                 dec_valid_q;
    ifd_pkg::ifd_fields_t fields_q;
    ifd_pkg::ifd_branch_t branch_q;
    ifd_pkg::ifd_class_t  class_q;
    logic                 invalid_form_q;
    int                   bad_count = 0;
    int                   checks_done = 0;
    int                   cycles = 0;

    always #2.5 clk = ~clk;

    ifd_fetch_model u_fm (.clk(clk), .instr_valid(instr_valid), .instr(instr),
        .instr_addr(instr_addr));
    ifd_decoder u_dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr(instr), .instr_addr(instr_addr), .dec_valid_q(dec_valid_q),
        .fields_q(fields_q), .branch_q(branch_q), .class_q(class_q),
        .invalid_form_q(invalid_form_q));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Whole run is well under this; a hang lands here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xfer(input logic [31:0] w, input logic [31:0] a);
        u_fm.put(w, a);
        u_fm.idle();
        #1;
        chk("dec_valid", {31'h0, dec_valid_q}, 32'h1);
    endtask

    task automatic test_fields();
        xfer({6'h13, 5'h15, 5'h0a, 5'h13, 10'h101, 1'b0}, 32'h0000_0100);
        chk("opcode", {26'h0, fields_q.opcode}, 32'h13);
        chk("bit_dest", {27'h0, fields_q.cond_bit_dest}, 32'h15);
        chk("bit_src1", {27'h0, fields_q.cond_bit_src_first}, 32'h0a);
        chk("bit_src2", {27'h0, fields_q.cond_bit_src_second}, 32'h13);
        chk("fld_dest", {29'h0, fields_q.cond_field_dest}, 32'h5);
        chk("fld_src", {29'h0, fields_q.cond_field_src}, 32'h2);
        chk("invalid", {31'h0, invalid_form_q}, 32'h0);
        chk("fld_cls", {30'h0, class_q}, {30'h0, ifd_pkg::IFD_CLS_OTHER});
        $display("test fields done");
    endtask

    // Negative displacements, unaligned address, both target modes
    task automatic test_branches();
        logic [31:0] a;
        logic [31:0] d;
        logic [13:0] bd;
        logic [23:0] li;
        a = 32'h0000_1003;
        bd = 14'h2ffc;
        li = 24'h80_0010;
        for (int aa = 0; aa < 2; aa++) begin
            xfer({6'h10, 5'h0c, 5'h1d, bd, aa[0], 1'b1}, a);
            d = {{16{bd[13]}}, bd, 2'b00};
            chk("bc_tgt", branch_q.target, aa ? d : {a[31:2], 2'b00} + d);
            chk("bc_abs", {31'h0, fields_q.absolute_target_flag}, aa);
            chk("bc_link", branch_q.link_addr, {a[31:2], 2'b00} + 32'h4);
            chk("bc_lwe", {31'h0, branch_q.link_we}, 32'h1);
            chk("bo", {27'h0, fields_q.branch_option_code}, 32'h0c);
            chk("bi", {27'h0, fields_q.branch_test_select}, 32'h1d);
            chk("bc_cls", {30'h0, class_q}, {30'h0, ifd_pkg::IFD_CLS_BCOND});
            xfer({6'h12, li, aa[0], 1'b0}, a);
            d = {{6{li[23]}}, li, 2'b00};
            chk("b_tgt", branch_q.target, aa ? d : {a[31:2], 2'b00} + d);
            chk("b_low", {30'h0, branch_q.target[1:0]}, 32'h0);
            chk("b_lwe", {31'h0, branch_q.link_we}, 32'h0);
            chk("b_isbr", {31'h0, branch_q.is_branch}, 32'h1);
            chk("b_cls", {30'h0, class_q}, {30'h0, ifd_pkg::IFD_CLS_BUNC});
        end
        $display("test branches done");
    endtask

    // Back to back, valid and invalid forms mixed
    task automatic test_forms();
        logic [31:0] bw [6];
        logic        ex [6];
        logic [31:0] ec;
        bw = '{{6'h13, 3'd5, 2'b00, 3'd2, 18'h0}, {6'h13, 3'd5, 2'b10, 3'd2, 18'h0},
               {6'h13, 3'd5, 2'b00, 3'd2, 18'h04000}, {6'h13, 3'd5, 2'b00, 3'd2, 18'h1},
               {6'h3f, 3'd1, 2'b00, 3'd3, 7'h0, 10'h040, 1'b0},
               {6'h13, 5'h1, 5'h2, 5'h3, 10'h101, 1'b1}};
        ex = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i <= 6; i++) begin
            if (i < 6)
                u_fm.put(bw[i], 32'h0000_2000);
            else
                u_fm.idle();
            if (i > 0) begin
                #1;
                chk("form_valid", {31'h0, dec_valid_q}, 32'h1);
                chk("form_bad", {31'h0, invalid_form_q}, {31'h0, ex[i-1]});
                ec = (i < 6) ? {30'h0, ifd_pkg::IFD_CLS_CRFLD} : {30'h0, ifd_pkg::IFD_CLS_OTHER};
                chk("form_cls", {30'h0, class_q}, ec);
            end
        end
        @(posedge clk);
        #1;
        chk("bad_pulse", {31'h0, invalid_form_q}, 32'h0);
        chk("valid_pulse", {31'h0, dec_valid_q}, 32'h0);
        chk("opc_held", {26'h0, fields_q.opcode}, 32'h13);
        $display("test forms done");
    endtask

    // Mid-run reset clears the held outputs, then a word decodes again
    task automatic test_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst_opc", {26'h0, fields_q.opcode}, 32'h0);
        chk("rst_tgt", branch_q.target, 32'h0);
        chk("rst_cls", {30'h0, class_q}, 32'h0);
        @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        xfer({6'h12, 24'h00_0040, 1'b0, 1'b1}, 32'h0000_3000);
        chk("rst_tgt2", branch_q.target, 32'h0000_3100);
        chk("rst_link", branch_q.link_addr, 32'h0000_3004);
        $display("test reset done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("rst_valid", {31'h0, dec_valid_q}, 32'h0);
        chk("rst_inv", {31'h0, invalid_form_q}, 32'h0);
        test_fields();
        test_branches();
        test_forms();
        test_reset();
        print_verdict();
    end
endmodule
